/* File: core/power_mode_clock_supervisor.sv */
// power mode controller with clock supervision behind an axi4-lite slave
`timescale 1ns/100ps
module power_mode_clock_supervisor #(
  parameter int NMOD  = 8,
  parameter int PDIV  = 4,
  parameter int CNT_W = 16
) (
  input  wire logic                  aclk,
  input  wire logic                  aresetn,
  input  wire logic [7:0]            s_axi_awaddr,
  input  wire logic                  s_axi_awvalid,
  output logic                       s_axi_awready,
  input  wire logic [31:0]           s_axi_wdata,
  input  wire logic [3:0]            s_axi_wstrb,
  input  wire logic                  s_axi_wvalid,
  output logic                       s_axi_wready,
  output logic [1:0]                 s_axi_bresp,
  output logic                       s_axi_bvalid,
  input  wire logic                  s_axi_bready,
  input  wire logic [7:0]            s_axi_araddr,
  input  wire logic                  s_axi_arvalid,
  output logic                       s_axi_arready,
  output logic [31:0]                s_axi_rdata,
  output logic [1:0]                 s_axi_rresp,
  output logic                       s_axi_rvalid,
  input  wire logic                  s_axi_rready,
  input  wire logic                  wait_for_irq,
  input  wire logic                  wake_irq,
  input  wire logic                  main_osc_alive,
  input  wire logic                  pll_ref_alive,
  input  wire logic                  target_clk_tick,
  input  wire logic                  ext_ref_tick,
  input  wire logic                  int_ref_tick,
  output pwr_clk_pkg::gate_type      gates,
  output pwr_clk_pkg::clk_src_type   sys_clk_src,
  output logic                       pll_free_running,
  output pwr_clk_pkg::op_level_type  op_level,
  output logic [NMOD-1:0]            module_stop,
  output logic [31:0]                periph_reg,
  output logic [pwr_clk_pkg::RETAIN_W-1:0] retained,
  output logic                       irq
);

  localparam int DIV_W = $clog2(PDIV + 1);

  pwr_clk_pkg::mode_type     mode_q;
  pwr_clk_pkg::mode_type     req_mode_q;
  pwr_clk_pkg::clk_src_type  clksel_q;
  pwr_clk_pkg::clk_src_type  wake_src_q;
  logic                      wake_sw_q;
  pwr_clk_pkg::op_level_type oplevel_q;
  logic [NMOD-1:0]           mstop_q;
  logic [31:0]               fam_ctl_q;
  logic [31:0]               fam_lim_q;
  logic [CNT_W-1:0]          fam_cnt_q;
  logic [CNT_W-1:0]          fam_res_q;
  logic [CNT_W-1:0]          fam_win_q;
  logic                      fam_busy_q;
  logic [pwr_clk_pkg::IRQ_W-1:0] irq_st_q;
  logic [pwr_clk_pkg::IRQ_W-1:0] irq_msk_q;
  logic [pwr_clk_pkg::RETAIN_W-1:0] retain_q;
  logic [31:0]               periph_q;
  logic [DIV_W-1:0]          div_q;
  logic                      ptick;
  logic                      pend_q;
  logic [31:0]               pend_data_q;
  logic                      aw_q;
  logic [7:0]                awaddr_q;
  logic                      w_q;
  logic [31:0]               wdata_q;
  logic [3:0]                wstrb_q;
  logic                      ar_q;
  logic [7:0]                araddr_q;
  logic                      wr_go;
  logic                      rd_go;
  logic                      main_stop_q;
  logic                      ref_tick;
  logic [pwr_clk_pkg::IRQ_W-1:0] irq_set;

  // lane-merged write of a 32-bit word
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                        input logic [3:0] strb);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        r[i*8 +: 8] = nw[i*8 +: 8];
      end
    end
    return r;
  endfunction : merge

  // bus channels: address and data captured in either order
  assign s_axi_awready = !aw_q && !s_axi_bvalid;
  assign s_axi_wready  = !w_q && !s_axi_bvalid;
  assign s_axi_arready = !ar_q && !s_axi_rvalid;
  assign wr_go = aw_q && w_q && !s_axi_bvalid;
  // a read behind a pending posted write waits for it
  assign rd_go = ar_q && !s_axi_rvalid && !pend_q;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_q     <= 1'b0;
      awaddr_q <= 8'h00;
      w_q      <= 1'b0;
      wdata_q  <= 32'h0000_0000;
      wstrb_q  <= 4'h0;
      ar_q     <= 1'b0;
      araddr_q <= 8'h00;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_q     <= 1'b1;
        awaddr_q <= s_axi_awaddr;
      end else if (wr_go) begin
        aw_q <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_q     <= 1'b1;
        wdata_q <= s_axi_wdata;
        wstrb_q <= s_axi_wstrb;
      end else if (wr_go) begin
        w_q <= 1'b0;
      end
      if (s_axi_arvalid && s_axi_arready) begin
        ar_q     <= 1'b1;
        araddr_q <= s_axi_araddr;
      end else if (rd_go) begin
        ar_q <= 1'b0;
      end
    end
  end

  // write response: posted write answers at once, before the peripheral applies it
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= pwr_clk_pkg::RESP_OKAY;
    end else if (wr_go) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= (awaddr_q > pwr_clk_pkg::OFF_STATUS || awaddr_q[1:0] != 2'h0) ?
                      pwr_clk_pkg::RESP_SLVERR : pwr_clk_pkg::RESP_OKAY;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // peripheral clock enable divided from aclk
  assign ptick = (div_q == DIV_W'(PDIV - 1));
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      div_q <= '0;
    end else begin
      div_q <= ptick ? '0 : div_q + 1'b1;
    end
  end

  // posted peripheral register, applied on the peripheral clock
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pend_q      <= 1'b0;
      pend_data_q <= 32'h0000_0000;
      periph_q    <= 32'h0000_0000;
    end else begin
      if (wr_go && awaddr_q == pwr_clk_pkg::OFF_PERIPH && !mstop_q[0]) begin
        pend_q      <= 1'b1;
        pend_data_q <= merge(pend_q ? pend_data_q : periph_q, wdata_q, wstrb_q);
      end else if (pend_q && ptick) begin
        pend_q   <= 1'b0;
        periph_q <= pend_data_q;
      end
    end
  end

  // control registers in the system clock domain
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      req_mode_q <= pwr_clk_pkg::MODE_RUN;
      wake_src_q <= pwr_clk_pkg::CLKSEL_RST;
      wake_sw_q  <= 1'b0;
      oplevel_q  <= pwr_clk_pkg::LVL_HIGH;
      mstop_q    <= '1;
      fam_ctl_q  <= 32'h0000_0000;
      fam_lim_q  <= 32'h0000_0000;
      irq_msk_q  <= '0;
      retain_q   <= '0;
    end else begin
      if (fam_busy_q) begin
        fam_ctl_q[pwr_clk_pkg::FAM_START] <= 1'b0;
      end
      if (wr_go) begin
        case (awaddr_q)
          pwr_clk_pkg::OFF_MODE: begin
            req_mode_q <= pwr_clk_pkg::mode_type'(wdata_q[2:0]);
            wake_src_q <= pwr_clk_pkg::clk_src_type'(wdata_q[6:4]);
            wake_sw_q  <= wdata_q[7];
          end
          // level order against clock is the software's duty
          pwr_clk_pkg::OFF_OPLEVEL: oplevel_q <= pwr_clk_pkg::op_level_type'(wdata_q[1:0]);
          pwr_clk_pkg::OFF_MSTOP:   mstop_q   <= wdata_q[NMOD-1:0];
          pwr_clk_pkg::OFF_FAM_CTL: fam_ctl_q <= merge(fam_ctl_q, wdata_q, wstrb_q);
          pwr_clk_pkg::OFF_FAM_LIM: fam_lim_q <= merge(fam_lim_q, wdata_q, wstrb_q);
          pwr_clk_pkg::OFF_IRQ_MSK: irq_msk_q <= wdata_q[pwr_clk_pkg::IRQ_W-1:0];
          pwr_clk_pkg::OFF_RETAIN:  retain_q  <= wdata_q[pwr_clk_pkg::RETAIN_W-1:0];
          default: ;
        endcase
      end
    end
  end

  // standby level sequencing
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      mode_q <= pwr_clk_pkg::MODE_RUN;
    end else begin
      case (mode_q)
        pwr_clk_pkg::MODE_RUN: begin
          if (wait_for_irq) begin
            mode_q <= req_mode_q;
          end
        end
        pwr_clk_pkg::MODE_DEEPSTB: mode_q <= mode_q;
        default: begin
          if (wake_irq) begin
            mode_q <= pwr_clk_pkg::MODE_RUN;
          end
        end
      endcase
    end
  end

  // system clock source: software choice, wake switch and oscillator stop fallback
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      clksel_q    <= pwr_clk_pkg::CLKSEL_RST;
      main_stop_q <= 1'b0;
    end else begin
      main_stop_q <= !main_osc_alive;
      if (!main_osc_alive && clksel_q == pwr_clk_pkg::SRC_MAIN) begin
        clksel_q <= pwr_clk_pkg::SRC_SLOW_OSC;
      end else if (mode_q == pwr_clk_pkg::MODE_SLEEP && wake_irq && wake_sw_q) begin
        clksel_q <= wake_src_q;
      end else if (wr_go && awaddr_q == pwr_clk_pkg::OFF_CLKSEL) begin
        clksel_q <= pwr_clk_pkg::clk_src_type'(wdata_q[2:0]);
      end
    end
  end

  assign pll_free_running = (clksel_q == pwr_clk_pkg::SRC_PLL) && !pll_ref_alive;

  // frequency accuracy monitor: count target ticks over a window of reference ticks
  assign ref_tick = fam_ctl_q[pwr_clk_pkg::FAM_REF_EXT] ? ext_ref_tick : int_ref_tick;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      fam_busy_q <= 1'b0;
      fam_cnt_q  <= '0;
      fam_win_q  <= '0;
      fam_res_q  <= '0;
    end else if (!fam_busy_q) begin
      if (fam_ctl_q[pwr_clk_pkg::FAM_START]) begin
        fam_busy_q <= 1'b1;
        fam_cnt_q  <= '0;
        fam_win_q  <= fam_ctl_q[pwr_clk_pkg::FAM_WIN_LSB +: CNT_W];
      end
    end else begin
      if (target_clk_tick) begin
        fam_cnt_q <= fam_cnt_q + 1'b1;
      end
      if (ref_tick) begin
        if (fam_win_q <= CNT_W'(1)) begin
          fam_busy_q <= 1'b0;
          fam_res_q  <= fam_cnt_q + CNT_W'(target_clk_tick);
        end
        fam_win_q <= fam_win_q - 1'b1;
      end
    end
  end

  // interrupt events; set wins over read clear
  always_comb begin
    irq_set = '0;
    if (fam_busy_q && ref_tick && fam_win_q <= CNT_W'(1)) begin
      irq_set[pwr_clk_pkg::IRQ_MEAS_DONE] = 1'b1;
      if ((fam_cnt_q + CNT_W'(target_clk_tick)) > fam_lim_q[31:16] ||
          (fam_cnt_q + CNT_W'(target_clk_tick)) < fam_lim_q[15:0]) begin
        irq_set[pwr_clk_pkg::IRQ_OUT_RANGE] = 1'b1;
      end
    end
    irq_set[pwr_clk_pkg::IRQ_OSC_STOP] = !main_osc_alive && !main_stop_q;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq_st_q <= '0;
    end else if (rd_go && araddr_q == pwr_clk_pkg::OFF_IRQ_ST) begin
      irq_st_q <= irq_set;
    end else begin
      irq_st_q <= irq_st_q | irq_set;
    end
  end

  assign irq = |(irq_st_q & irq_msk_q);

  // read data path
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h0000_0000;
      s_axi_rresp  <= pwr_clk_pkg::RESP_OKAY;
    end else if (rd_go) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp  <= pwr_clk_pkg::RESP_OKAY;
      case (araddr_q)
        pwr_clk_pkg::OFF_MODE:    s_axi_rdata <= {24'h0, wake_sw_q, wake_src_q, 1'b0, req_mode_q};
        pwr_clk_pkg::OFF_CLKSEL:  s_axi_rdata <= {29'h0, clksel_q};
        pwr_clk_pkg::OFF_OPLEVEL: s_axi_rdata <= {30'h0, oplevel_q};
        pwr_clk_pkg::OFF_MSTOP:   s_axi_rdata <= 32'(mstop_q);
        pwr_clk_pkg::OFF_FAM_CTL: s_axi_rdata <= fam_ctl_q;
        pwr_clk_pkg::OFF_FAM_LIM: s_axi_rdata <= fam_lim_q;
        pwr_clk_pkg::OFF_FAM_CNT: s_axi_rdata <= {15'h0, fam_busy_q, fam_res_q};
        pwr_clk_pkg::OFF_IRQ_ST:  s_axi_rdata <= 32'(irq_st_q);
        pwr_clk_pkg::OFF_IRQ_MSK: s_axi_rdata <= 32'(irq_msk_q);
        pwr_clk_pkg::OFF_RETAIN:  s_axi_rdata <= 32'(retain_q);
        pwr_clk_pkg::OFF_PERIPH:  s_axi_rdata <= mstop_q[0] ? 32'h0000_0000 : periph_q;
        pwr_clk_pkg::OFF_STATUS:  s_axi_rdata <= {28'h0, pll_free_running, mode_q};
        default: begin
          s_axi_rdata <= 32'h0000_0000;
          s_axi_rresp <= pwr_clk_pkg::RESP_SLVERR;
        end
      endcase
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // clock and power gating per standby level
  always_comb begin
    gates = '1;
    case (mode_q)
      pwr_clk_pkg::MODE_RUN: ;
      pwr_clk_pkg::MODE_SLEEP: begin
        gates.cpu = 1'b0;
        gates.wdt = 1'b0;
      end
      pwr_clk_pkg::MODE_DSLEEP: begin
        gates[12:7] = 6'h00;
      end
      pwr_clk_pkg::MODE_ALLSTOP: begin
        gates[12:6] = 7'h00;
      end
      pwr_clk_pkg::MODE_SWSTBY: begin
        // independent watchdog, sub oscillator and rtc keep running
        gates[12:4] = 9'h000;
      end
      default: begin
        // only sub oscillator and rtc survive the power cut
        gates[12:3] = 10'h000;
        gates.core_pwr = 1'b0;
      end
    endcase
  end

  assign sys_clk_src = clksel_q;
  assign op_level    = oplevel_q;
  assign module_stop = mstop_q;
  assign periph_reg  = periph_q;
  assign retained    = retain_q;

endmodule : power_mode_clock_supervisor

/* File: core/pwr_clk_pkg.sv */
// constants and types of the power mode and clock supervisor
package pwr_clk_pkg;

  // register byte offsets
  localparam logic [7:0] OFF_MODE    = 8'h00;
  localparam logic [7:0] OFF_CLKSEL  = 8'h04;
  localparam logic [7:0] OFF_OPLEVEL = 8'h08;
  localparam logic [7:0] OFF_MSTOP   = 8'h0C;
  localparam logic [7:0] OFF_FAM_CTL = 8'h10;
  localparam logic [7:0] OFF_FAM_LIM = 8'h14;
  localparam logic [7:0] OFF_FAM_CNT = 8'h18;
  localparam logic [7:0] OFF_IRQ_ST  = 8'h1C;
  localparam logic [7:0] OFF_IRQ_MSK = 8'h20;
  localparam logic [7:0] OFF_RETAIN  = 8'h24;
  localparam logic [7:0] OFF_PERIPH  = 8'h28;
  localparam logic [7:0] OFF_STATUS  = 8'h2C;

  // interrupt status bit positions
  localparam int IRQ_MEAS_DONE = 0;
  localparam int IRQ_OUT_RANGE = 1;
  localparam int IRQ_OSC_STOP  = 2;
  localparam int IRQ_W         = 3;

  // field positions of the frequency monitor control
  localparam int FAM_START   = 0;
  localparam int FAM_REF_EXT = 1;
  localparam int FAM_WIN_LSB = 8;

  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // standby levels, gray coded along deepening
  typedef enum logic [2:0] {
    MODE_RUN     = 3'h0,
    MODE_SLEEP   = 3'h1,
    MODE_DSLEEP  = 3'h3,
    MODE_ALLSTOP = 3'h2,
    MODE_SWSTBY  = 3'h6,
    MODE_DEEPSTB = 3'h7
  } mode_type;

  typedef enum logic [2:0] {
    SRC_SLOW_OSC = 3'h0,
    SRC_FAST_OSC = 3'h1,
    SRC_MAIN     = 3'h2,
    SRC_SUB      = 3'h3,
    SRC_PLL      = 3'h4
  } clk_src_type;

  typedef enum logic [1:0] {
    LVL_HIGH   = 2'h0,
    LVL_MIDDLE = 2'h1,
    LVL_LOW    = 2'h2
  } op_level_type;

  // clock and power enables towards the chip
  typedef struct packed {
    logic cpu;
    logic wdt;
    logic dma;
    logic xfer;
    logic rom;
    logic ram;
    logic periph;
    logic main_osc;
    logic tmr8;
    logic independent_watchdog;
    logic sub_osc;
    logic rtc;
    logic core_pwr;
  } gate_type;

  localparam clk_src_type CLKSEL_RST = SRC_SLOW_OSC;
  localparam int          RETAIN_W   = 18;

endpackage : pwr_clk_pkg

/* File: sim/power_mode_clock_supervisor_monitor.sv */
// port checker of the power mode and clock supervisor
`timescale 1ns/100ps
module power_mode_clock_supervisor_monitor #(
  parameter int NMOD = 8
) (
  input wire logic                      aclk,
  input wire logic                      aresetn,
  input wire logic                      s_axi_awvalid,
  input wire logic                      s_axi_awready,
  input wire logic                      s_axi_wvalid,
  input wire logic                      s_axi_wready,
  input wire logic                      s_axi_bvalid,
  input wire logic                      s_axi_bready,
  input wire logic                      s_axi_arvalid,
  input wire logic                      s_axi_arready,
  input wire logic                      s_axi_rvalid,
  input wire logic                      wake_irq,
  input wire logic                      main_osc_alive,
  input wire logic                      pll_ref_alive,
  input wire pwr_clk_pkg::gate_type     gates,
  input wire pwr_clk_pkg::clk_src_type  sys_clk_src,
  input wire logic                      pll_free_running,
  input wire pwr_clk_pkg::op_level_type op_level,
  input wire logic [NMOD-1:0]           module_stop,
  input wire logic [31:0]               periph_reg
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  // a write is in flight from address accept until its response is taken
  logic wr_busy_q;
  always_ff @(posedge aclk) begin
    if (!aresetn) wr_busy_q <= 1'h0;
    else if (s_axi_awvalid && s_axi_awready) wr_busy_q <= 1'h1;
    else if (s_axi_bvalid && s_axi_bready) wr_busy_q <= 1'h0;
  end

  property p_gate_pairs;
    gates.cpu == gates.wdt && gates.independent_watchdog == gates.core_pwr && gates.sub_osc && gates.rtc;
  endproperty
  a_gate_pairs: assert property (p_gate_pairs) else $error("gate pairing broken");
  property p_gate_nest;
    !gates.periph |-> !gates.ram && !gates.rom && !gates.dma && !gates.xfer && !gates.cpu;
  endproperty
  a_gate_nest: assert property (p_gate_nest) else $error("gate nesting broken");
  property p_gate_stby;
    !gates.main_osc |-> !gates.periph && !gates.tmr8;
  endproperty
  a_gate_stby: assert property (p_gate_stby) else $error("standby gates wrong");
  property p_deep;
    !gates.core_pwr |-> gates == 13'h0006;
  endproperty
  a_deep: assert property (p_deep) else $error("deep standby gates wrong");
  property p_deep_stay;
    !gates.core_pwr |=> !gates.core_pwr;
  endproperty
  a_deep_stay: assert property (p_deep_stay) else $error("deep standby left");
  property p_fall;
    sys_clk_src == pwr_clk_pkg::SRC_MAIN && !main_osc_alive
      |-> ##[1:3] sys_clk_src == pwr_clk_pkg::SRC_SLOW_OSC;
  endproperty
  a_fall: assert property (p_fall) else $error("no fallback clock");
  property p_keep;
    gates.cpu && !wr_busy_q && sys_clk_src != pwr_clk_pkg::SRC_MAIN |=> $stable(sys_clk_src);
  endproperty
  a_keep: assert property (p_keep) else $error("clock source changed");
  property p_pll;
    pll_free_running == (sys_clk_src == pwr_clk_pkg::SRC_PLL && !pll_ref_alive);
  endproperty
  a_pll: assert property (p_pll) else $error("pll free run flag wrong");
  property p_lvl;
    op_level inside {pwr_clk_pkg::LVL_HIGH, pwr_clk_pkg::LVL_MIDDLE, pwr_clk_pkg::LVL_LOW};
  endproperty
  a_lvl: assert property (p_lvl) else $error("illegal operating level");
  property p_posted;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##2 s_axi_bvalid;
  endproperty
  a_posted: assert property (p_posted) else $error("write response late");
  property p_rd;
    s_axi_arvalid && s_axi_arready |-> ##[2:8] s_axi_rvalid;
  endproperty
  a_rd: assert property (p_rd) else $error("read answer late");
  property p_stop;
    module_stop[0] |=> $stable(periph_reg);
  endproperty
  a_stop: assert property (p_stop) else $error("stopped module register changed");
  property p_wake;
    !gates.cpu && gates.core_pwr && wake_irq |-> ##[1:2] gates.cpu;
  endproperty
  a_wake: assert property (p_wake) else $error("no wake on interrupt");

  c_sleep: cover property ($fell(gates.cpu));
  c_deep: cover property (!gates.core_pwr);
  c_fall: cover property (sys_clk_src == pwr_clk_pkg::SRC_MAIN ##1 sys_clk_src == 3'h0);
  c_pll: cover property (pll_free_running);
endmodule : power_mode_clock_supervisor_monitor

bind power_mode_clock_supervisor power_mode_clock_supervisor_monitor #(.NMOD(NMOD)) u_mon (
  .aclk(aclk), .aresetn(aresetn), .s_axi_awvalid(s_axi_awvalid),
  .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
  .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_arvalid(s_axi_arvalid),
  .s_axi_arready(s_axi_arready), .s_axi_rvalid(s_axi_rvalid), .wake_irq(wake_irq),
  .main_osc_alive(main_osc_alive), .pll_ref_alive(pll_ref_alive), .gates(gates),
  .sys_clk_src(sys_clk_src), .pll_free_running(pll_free_running), .op_level(op_level),
  .module_stop(module_stop), .periph_reg(periph_reg)
);

/* File: sim/power_mode_clock_supervisor_tb.sv */
// self-checking bench of the power mode and clock supervisor
`timescale 1ns/100ps
module power_mode_clock_supervisor_tb;
  logic                      aclk = 1'h0, aresetn = 1'h0;
  logic [7:0]                awaddr = 8'h00, araddr = 8'h00, cyc = 8'h00;
  logic [31:0]               wdata = 32'h0, seed = 32'hF72938D6;
  logic                      awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0;
  logic                      arvalid = 1'h0, rready = 1'h0, wfi = 1'h0, wake = 1'h0;
  logic                      main_ok = 1'h1, pll_ok = 1'h1, tgt = 1'h0, ext = 1'h0, intr = 1'h0;
  logic                      awready, wready, bvalid, arready, rvalid, pll_fr, irq;
  logic [1:0]                bresp, rresp;
  logic [31:0]               rdata, periph;
  logic [7:0]                mstop;
  logic [17:0]               retained;
  pwr_clk_pkg::gate_type     gates;
  pwr_clk_pkg::clk_src_type  src;
  pwr_clk_pkg::op_level_type op_level;
  int                        n_mismatch = 0, checked = 0;
  logic [33:0]               rq[$];
  logic [1:0]                bq[$];
  logic [7:0]                mtab[4] = '{8'h01, 8'h03, 8'h02, 8'h06};
  logic [12:0]               gtab[4] = '{13'h07FF, 13'h007F, 13'h003F, 13'h000F};

  power_mode_clock_supervisor #(.NMOD(8), .PDIV(4), .CNT_W(16)) u_dut (
    .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .wait_for_irq(wfi), .wake_irq(wake), .main_osc_alive(main_ok), .pll_ref_alive(pll_ok),
    .target_clk_tick(tgt), .ext_ref_tick(ext), .int_ref_tick(intr), .gates(gates),
    .sys_clk_src(src), .pll_free_running(pll_fr), .op_level(op_level), .module_stop(mstop),
    .periph_reg(periph), .retained(retained), .irq(irq)
  );

  initial forever #5 aclk = ~aclk;

  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction : rnd

  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    checked++;
    if (got !== exp) begin
      n_mismatch++;
      $display("unexpected %s: expected %h seen %h", name, exp, got);
    end
  endtask : chk

  task automatic give_verdict();
    $display("comparisons %0d mismatches %0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : give_verdict

  task automatic do_reset();
    aresetn <= 1'h0;
    repeat (5) @(posedge aclk);
    aresetn <= 1'h1;
    @(posedge aclk);
  endtask : do_reset

  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r = 2'h0);
    bq.push_back(r);
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'h1;
    wvalid <= 1'h1;
    bready <= 1'h1;
    do begin
      @(posedge aclk);
      if (awvalid && awready) awvalid <= 1'h0;
      if (wvalid && wready) wvalid <= 1'h0;
    end while (!(bvalid && bready));
    bready <= 1'h0;
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r = 2'h0);
    rq.push_back({r, d});
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'h1;
    rready <= 1'h1;
    do begin
      @(posedge aclk);
      if (arvalid && arready) arvalid <= 1'h0;
    end while (!(rvalid && rready));
    rready <= 1'h0;
  endtask : rd

  task automatic enter(input logic [7:0] m);
    wr(pwr_clk_pkg::OFF_MODE, {24'h0, m});
    rd(pwr_clk_pkg::OFF_MODE, {24'h0, m});
    @(posedge aclk);
    wfi <= 1'h1;
    @(posedge aclk);
    wfi <= 1'h0;
    repeat (2) @(posedge aclk);
  endtask : enter

  task automatic wakeup();
    wake <= 1'h1;
    @(posedge aclk);
    wake <= 1'h0;
    repeat (3) @(posedge aclk);
  endtask : wakeup

  // measured and reference clock edges
  always @(posedge aclk) begin
    cyc <= cyc + 8'h01;
    tgt <= cyc[0] | cyc[1];
    ext <= cyc[1:0] == 2'h0;
    intr <= cyc[0];
  end

  // response watcher: each answer is compared with the oldest noted expectation
  always @(posedge aclk) begin
    logic [33:0] e;
    if (rvalid && rready && rq.size() > 0) begin
      e = rq.pop_front();
      chk("read data", e[31:0], rdata);
      chk("read response", 32'(e[33:32]), 32'(rresp));
    end
    if (bvalid && bready && bq.size() > 0) chk("write response", 32'(bq.pop_front()), 32'(bresp));
  end

  initial begin
    repeat (20000) @(posedge aclk);
    n_mismatch++;
    give_verdict();
  end

  initial begin
    logic [31:0] d;
    do_reset();
    chk("gates", 32'h1FFF, 32'(gates));
    chk("op level", 32'h0, 32'(op_level));
    chk("module stop", 32'hFF, 32'(mstop));
    rd(8'hFC, 32'h0, pwr_clk_pkg::RESP_SLVERR);
    wr(8'hFE, rnd(), pwr_clk_pkg::RESP_SLVERR);
    wr(pwr_clk_pkg::OFF_PERIPH, rnd());
    rd(pwr_clk_pkg::OFF_PERIPH, 32'h0);
    wr(pwr_clk_pkg::OFF_MSTOP, 32'h0);
    d = rnd();
    wr(pwr_clk_pkg::OFF_PERIPH, d);
    rd(pwr_clk_pkg::OFF_PERIPH, d);
    chk("peripheral register", d, periph);
    wr(pwr_clk_pkg::OFF_CLKSEL, 32'h0);
    wr(pwr_clk_pkg::OFF_OPLEVEL, 32'h2);
    chk("op level", 32'h2, 32'(op_level));
    wr(pwr_clk_pkg::OFF_OPLEVEL, 32'h1);
    wr(pwr_clk_pkg::OFF_CLKSEL, 32'h1);
    rd(pwr_clk_pkg::OFF_OPLEVEL, 32'h1);
    chk("clock source", 32'h1, 32'(src));
    wr(pwr_clk_pkg::OFF_MSTOP, 32'hFF);
    for (int i = 0; i < 4; i++) begin
      enter(mtab[i]);
      chk("gates", 32'(gtab[i]), 32'(gates));
      wakeup();
      chk("gates", 32'h1FFF, 32'(gates));
    end
    wr(pwr_clk_pkg::OFF_CLKSEL, 32'h0);
    enter(8'hB1);
    wakeup();
    chk("clock source", 32'(pwr_clk_pkg::SRC_SUB), 32'(src));
    d = rnd();
    wr(pwr_clk_pkg::OFF_RETAIN, d);
    rd(pwr_clk_pkg::OFF_RETAIN, 32'(d[17:0]));
    enter(8'h07);
    chk("gates", 32'h0006, 32'(gates));
    chk("retained", 32'(d[17:0]), 32'(retained));
    wakeup();
    chk("gates", 32'h0006, 32'(gates));
    do_reset();
    chk("gates", 32'h1FFF, 32'(gates));
    wr(pwr_clk_pkg::OFF_IRQ_MSK, 32'h0);
    wr(pwr_clk_pkg::OFF_CLKSEL, 32'(pwr_clk_pkg::SRC_MAIN));
    main_ok <= 1'h0;
    repeat (4) @(posedge aclk);
    chk("clock source", 32'(pwr_clk_pkg::SRC_SLOW_OSC), 32'(src));
    chk("irq", 32'h0, 32'(irq));
    wr(pwr_clk_pkg::OFF_IRQ_MSK, 32'h4);
    @(posedge aclk);
    chk("irq", 32'h1, 32'(irq));
    rd(pwr_clk_pkg::OFF_IRQ_ST, 32'h4);
    repeat (2) @(posedge aclk);
    chk("irq", 32'h0, 32'(irq));
    wr(pwr_clk_pkg::OFF_CLKSEL, 32'(pwr_clk_pkg::SRC_PLL));
    pll_ok <= 1'h0;
    repeat (2) @(posedge aclk);
    chk("pll free run", 32'h1, 32'(pll_fr));
    chk("clock source", 32'(pwr_clk_pkg::SRC_PLL), 32'(src));
    rd(pwr_clk_pkg::OFF_STATUS, 32'h8);
    main_ok <= 1'h1;
    pll_ok <= 1'h1;
    wr(pwr_clk_pkg::OFF_IRQ_MSK, 32'h3);
    for (int k = 0; k < 2; k++) begin
      wr(pwr_clk_pkg::OFF_FAM_LIM, k ? 32'hFFFFFFF0 : 32'hFFFF0000);
      wr(pwr_clk_pkg::OFF_FAM_CTL, k ? 32'h0401 : 32'h0403);
      for (int n = 0; n < 500 && irq !== 1'h1; n++) @(posedge aclk);
      chk("irq", 32'h1, 32'(irq));
      @(posedge aclk);
      rd(pwr_clk_pkg::OFF_IRQ_ST, k ? 32'h3 : 32'h1);
    end
    repeat (2) @(posedge aclk);
    give_verdict();
  end
endmodule : power_mode_clock_supervisor_tb
